// file: verilog/spi_port_pkg.sv
// Register map, field layout and state type of the serial port
package spi_port_pkg;

    // Word addresses in the peripheral frame
    localparam logic [15:0] ADDR_CONFIG   = 16'h7040;
    localparam logic [15:0] ADDR_OPCTL    = 16'h7041;
    localparam logic [15:0] ADDR_STATUS   = 16'h7042;
    localparam logic [15:0] ADDR_RATE     = 16'h7044;
    localparam logic [15:0] ADDR_RXEMU    = 16'h7046;
    localparam logic [15:0] ADDR_RXBUF    = 16'h7047;
    localparam logic [15:0] ADDR_TXBUF    = 16'h7048;
    localparam logic [15:0] ADDR_SHIFT    = 16'h7049;
    localparam logic [15:0] ADDR_FIFO_TX  = 16'h704A;
    localparam logic [15:0] ADDR_FIFO_RX  = 16'h704B;
    localparam logic [15:0] ADDR_FIFO_CTL = 16'h704C;
    localparam logic [15:0] ADDR_PRIO     = 16'h704F;

    // config_control fields
    localparam int CFG_LEN_LSB = 0;
    localparam int CFG_LEN_W   = 4;
    localparam int CFG_POL     = 6;

    // operation_control fields
    localparam int CTL_RX_IE   = 0;
    localparam int CTL_TALK    = 1;
    localparam int CTL_MASTER  = 2;
    localparam int CTL_PHASE   = 3;
    localparam int CTL_TX_IE   = 4;
    localparam int CTL_PORT_EN = 5;

    // port_status fields
    localparam int STS_TX_FULL = 5;
    localparam int STS_RX_DONE = 6;
    localparam int STS_OVERRUN = 7;

    localparam int RATE_W = 7;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;

    localparam logic [7:0]        CONFIG_RESET  = 8'h00;
    localparam logic [7:0]        CONTROL_RESET = 8'h00;
    localparam logic [RATE_W-1:0] RATE_RESET    = 7'h00;

    // Shortest serial clock period in clk cycles
    localparam logic [7:0] PERIOD_FLOOR = 8'h04;

    typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_t;

endpackage : spi_port_pkg

// file: verilog/spi_rate_divider.sv
// Serial clock half-period enable generator for master mode
`timescale 1ns/1ps
module spi_rate_divider
    import spi_port_pkg::*;
#(
    parameter int PERIOD_W = 8
)
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              run,
    input  wire logic [RATE_W-1:0] rate,
    output logic                   tick
);

    if (PERIOD_W < RATE_W + 1) begin : g_bad_width
        $error("PERIOD_W too narrow for the rate field");
    end

    typedef struct packed {
        logic [PERIOD_W-1:0] cnt;
        logic                sel;
    } div_t;

    div_t                r;
    div_t                next_r;
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] half;
    logic [PERIOD_W-1:0] lim;
    logic [PERIOD_W-1:0] gap;

    always_comb begin
        if ({1'b0, rate} < PERIOD_FLOOR) begin
            period = PERIOD_W'(PERIOD_FLOOR); // RQ4
        end else begin
            period = PERIOD_W'(rate) + 1'b1; // RQ3
        end
        half = period >> 1;
        // Odd periods give the longer half after the lead edge
        lim = r.sel ? period - half : half;
        tick = run && (r.cnt == lim - 1'b1);
        next_r = r;
        if (!run) begin
            next_r = '0;
        end else if (tick) begin
            next_r.cnt = '0;
            next_r.sel = ~r.sel;
        end else begin
            next_r.cnt = r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Cycles since the last lead tick, zero when none seen
    always_ff @(posedge clk) begin
        if (!nrst || !run) begin
            gap <= '0;
        end else if (tick && !r.sel) begin
            gap <= PERIOD_W'(1);
        end else if (gap != '0) begin
            gap <= gap + 1'b1;
        end
    end

    a_full_period: assert property (@(posedge clk) disable iff (!nrst) // RQ3
        (tick && !r.sel && gap != '0 && $stable(rate)) |-> gap == period)
        else $error("serial clock period differs from divider setting");

    a_floor_rate: assert property (@(posedge clk) disable iff (!nrst) // RQ4
        (tick && ({1'b0, rate} < PERIOD_FLOOR)) ##1 (run && $stable(rate))
        ##1 (run && $stable(rate)) |-> tick && !$past(tick))
        else $error("low divider values do not give a period of four");

endmodule : spi_rate_divider

// file: verilog/spi_port_readback.sv
// Read data selection for the port registers
`timescale 1ns/1ps
module spi_port_readback
    import spi_port_pkg::*;
(
    input  wire logic [15:0]       addr,
    input  wire logic [7:0]        cfg,
    input  wire logic [7:0]        ctl,
    input  wire logic [7:0]        sts,
    input  wire logic [RATE_W-1:0] rate,
    input  wire logic [15:0]       rxbuf,
    input  wire logic [15:0]       txbuf,
    input  wire logic [15:0]       shreg,
    output logic [15:0]            data,
    output logic                   hit
);

    always_comb begin
        data = '0;
        hit  = 1'b1;
        case (addr)
            ADDR_CONFIG:   data = {8'h00, cfg};
            ADDR_OPCTL:    data = {8'h00, ctl};
            ADDR_STATUS:   data = {8'h00, sts};
            ADDR_RATE:     data = {9'h000, rate};
            ADDR_RXEMU,
            ADDR_RXBUF:    data = rxbuf;
            ADDR_TXBUF:    data = txbuf;
            ADDR_SHIFT:    data = shreg;
            ADDR_FIFO_TX,
            ADDR_FIFO_RX,
            ADDR_FIFO_CTL,
            ADDR_PRIO:     data = '0;
            default:       hit  = 1'b0;
        endcase
    end

endmodule : spi_port_readback

// file: verilog/spi_master_slave_port.sv
// Four-pin synchronous serial port, master or slave, with its registers
//
// Contract
// RQ1: Each transfer shifts a software-set word of one to sixteen bits.
// RQ2: Port runs as clock-making master or clock-taking slave, by software.
// RQ3: Master divider four or more gives clock rate clk over divider plus one.
// RQ4: Divider values zero to three give clock rate clk over four.
// RQ5: Polarity and phase bits pick one of four clocking schemes.
// RQ6: Idle-high, no delay: drive on falling edge, sample on rising edge.
// RQ7: Idle-high, delayed: drive half cycle early, sample on falling edge.
// RQ8: Idle-low, no delay: drive on rising edge, sample on falling edge.
// RQ9: Idle-low, delayed: drive half cycle early, sample on rising edge.
// RQ10: Receive and transmit together; software may turn transmit off.
// RQ11: Pollable transmit and receive flags with matching interrupt requests.
// RQ12: Register data in low byte; upper byte reads zero, ignores writes.
// RQ13: Control and status registers decoded from word address 7040h.
// RQ14: An unused port releases its four pins for general use.
// RQ15: External master pulls transmit-enable low to select this slave.
// RQ16: Software uses only 16-bit accesses to the port registers.
// RQ17: After the last bit, word goes to receive buffer, flag set.
// RQ18: Master starts on buffer or data write; clock idles between words.
`timescale 1ns/1ps
module spi_master_slave_port
    import spi_port_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic [15:0]      bus_rdata,
    output logic             bus_rvalid,
    output logic             rx_int_req,
    output logic             tx_int_req,
    input  wire logic        serial_clock_pin_level,
    output logic             serial_clock_pin_drive,
    output logic             serial_clock_pin_en,
    input  wire logic        slave_in_master_out_pin_level,
    output logic             slave_in_master_out_pin_drive,
    output logic             slave_in_master_out_pin_en,
    input  wire logic        slave_out_master_in_pin_level,
    output logic             slave_out_master_in_pin_drive,
    output logic             slave_out_master_in_pin_en,
    input  wire logic        slave_transmit_enable_pin_level,
    output logic             slave_transmit_enable_pin_drive,
    output logic             slave_transmit_enable_pin_en
);

    typedef struct packed {
        xfer_state_t       st;
        logic [7:0]        cfg;
        logic [7:0]        ctl;
        logic [RATE_W-1:0] rate;
        logic              rx_done;
        logic              overrun;
        logic              tx_full;
        logic              go;
        logic [15:0]       txbuf;
        logic [15:0]       rxbuf;
        logic [15:0]       sh;
        logic [4:0]        cnt;
        logic              out_bit;
        logic              sclk;
        logic              sclk_seen;
        logic              sclk_oe;
        logic              mo_oe;
        logic              so_oe;
        logic              ste_drive;
        logic              ste_oe;
        logic [15:0]       rdata;
        logic              rvalid;
        logic              rx_irq;
        logic              tx_irq;
    } port_t;

    port_t       r;
    port_t       next_r;
    logic        tick;
    logic        pol;
    logic        pha;
    logic        master;
    logic        en;
    logic        ste_low;
    logic        rx_in;
    logic [4:0]  len;
    logic [15:0] lenmask;
    logic        lead;
    logic        trail;
    logic        drive_ev;
    logic        sample_ev;
    logic        start;
    logic        finish;
    logic [15:0] ld_word;
    logic [7:0]  sts;
    logic [15:0] rd_word;
    logic        rd_hit;

    spi_rate_divider #(
        .PERIOD_W (8)
    ) u_div (
        .clk  (clk),
        .nrst (nrst),
        .run  (r.st == ST_SHIFT && master),
        .rate (r.rate),
        .tick (tick)
    );

    always_comb begin
        sts = '0;
        sts[STS_TX_FULL] = r.tx_full; // RQ11
        sts[STS_RX_DONE] = r.rx_done;
        sts[STS_OVERRUN] = r.overrun;
    end

    spi_port_readback u_rb (
        .addr  (bus_addr),
        .cfg   (r.cfg),
        .ctl   (r.ctl),
        .sts   (sts),
        .rate  (r.rate),
        .rxbuf (r.rxbuf),
        .txbuf (r.txbuf),
        .shreg (r.sh),
        .data  (rd_word),
        .hit   (rd_hit)
    );

    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        finish = 1'b0;
        pol = r.cfg[CFG_POL]; // RQ5
        pha = r.ctl[CTL_PHASE];
        master = r.ctl[CTL_MASTER]; // RQ2
        en = r.ctl[CTL_PORT_EN];
        ste_low = !slave_transmit_enable_pin_level;
        rx_in = master ? slave_out_master_in_pin_level
                       : slave_in_master_out_pin_level;
        len = 5'(r.cfg[CFG_LEN_LSB +: CFG_LEN_W]) + 5'h01; // RQ1
        lenmask = ~(16'hFFFF << len);
        // Lead edge leaves the idle level, trail edge returns to it
        if (master) begin
            lead  = tick && (r.sclk == pol);
            trail = tick && (r.sclk != pol);
        end else begin
            lead  = (r.st == ST_SHIFT) && ste_low && (r.sclk_seen == pol)
                    && (serial_clock_pin_level != pol);
            trail = (r.st == ST_SHIFT) && ste_low && (r.sclk_seen != pol)
                    && (serial_clock_pin_level == pol);
        end
        drive_ev  = pha ? trail : lead; // RQ6 RQ8
        sample_ev = pha ? lead : trail; // RQ7 RQ9
        start = (r.st == ST_IDLE) && en
                && (master ? (r.go || r.tx_full) : ste_low); // RQ18 RQ15
        ld_word = r.tx_full ? r.txbuf : r.sh;
        next_r.sclk_seen = serial_clock_pin_level;

        case (r.st)
            ST_IDLE: begin
                next_r.sclk = pol; // RQ18
                if (start) begin
                    next_r.st = ST_SHIFT;
                    next_r.cnt = '0;
                    next_r.go = 1'b0;
                    next_r.tx_full = 1'b0;
                    next_r.sh = ld_word;
                    // Delayed schemes put the first bit out at once
                    if (pha) begin
                        next_r.out_bit = ld_word[WORD_W-1]; // RQ7 RQ9
                        next_r.sh = {ld_word[WORD_W-2:0], 1'b0};
                    end
                end
            end
            ST_SHIFT: begin
                // Slave deselected mid-word drops the partial word
                if (!en || (!master && !ste_low)) begin
                    next_r.st = ST_IDLE; // RQ2
                end else begin
                    if (master && tick) begin
                        next_r.sclk = ~r.sclk; // RQ3 RQ4
                    end
                    if (drive_ev && r.cnt < len) begin
                        next_r.out_bit = r.sh[WORD_W-1]; // RQ10
                        next_r.sh = {r.sh[WORD_W-2:0], 1'b0};
                    end
                    if (sample_ev) begin
                        next_r.sh[0] = rx_in; // RQ10
                        next_r.cnt = r.cnt + 5'h01;
                    end
                    if (trail && next_r.cnt == len) begin
                        finish = 1'b1; // RQ1
                        next_r.st = ST_IDLE;
                        next_r.rxbuf = next_r.sh & lenmask; // RQ17
                        next_r.overrun = r.overrun || r.rx_done; // RQ11
                        next_r.rx_done = 1'b1; // RQ17
                    end
                end
            end
            default: next_r.st = ST_IDLE;
        endcase

        // A finishing word wins over the clearing read
        if (bus_rd && bus_addr == ADDR_RXBUF && !finish) begin
            next_r.rx_done = 1'b0; // RQ17
        end
        if (bus_rd) begin
            next_r.rvalid = 1'b1;
            next_r.rdata = rd_hit ? rd_word : '0; // RQ13 RQ12
        end
        if (bus_wr) begin
            case (bus_addr) // RQ13
                ADDR_CONFIG: next_r.cfg = bus_wdata[BYTE_W-1:0]; // RQ12
                ADDR_OPCTL:  next_r.ctl = bus_wdata[BYTE_W-1:0];
                ADDR_STATUS: begin
                    if (bus_wdata[STS_OVERRUN] && !(finish && r.rx_done)) begin
                        next_r.overrun = 1'b0;
                    end
                end
                ADDR_RATE:   next_r.rate = bus_wdata[RATE_W-1:0];
                ADDR_TXBUF: begin
                    next_r.txbuf = bus_wdata; // RQ18
                    next_r.tx_full = 1'b1;
                end
                ADDR_SHIFT: begin
                    // Ignored while a word is on the wire
                    if (r.st == ST_IDLE && !start) begin
                        next_r.sh = bus_wdata;
                        next_r.go = master; // RQ18
                    end
                end
                default: ;
            endcase
        end

        next_r.rx_irq = next_r.rx_done && next_r.ctl[CTL_RX_IE]; // RQ11
        next_r.tx_irq = !next_r.tx_full && next_r.ctl[CTL_TX_IE]; // RQ11
        // Disabled port floats all four pins for other use
        next_r.sclk_oe = next_r.ctl[CTL_PORT_EN]
                         && next_r.ctl[CTL_MASTER]; // RQ14
        next_r.ste_oe = next_r.sclk_oe;
        next_r.mo_oe = next_r.sclk_oe && next_r.ctl[CTL_TALK]; // RQ10
        next_r.so_oe = next_r.ctl[CTL_PORT_EN] && !next_r.ctl[CTL_MASTER]
                       && next_r.ctl[CTL_TALK] && ste_low; // RQ10 RQ15
        next_r.ste_drive = (next_r.st != ST_SHIFT);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
            r.cfg <= CONFIG_RESET;
            r.ctl <= CONTROL_RESET;
            r.rate <= RATE_RESET;
            r.ste_drive <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign bus_rdata                       = r.rdata;
    assign bus_rvalid                      = r.rvalid;
    assign rx_int_req                      = r.rx_irq;
    assign tx_int_req                      = r.tx_irq;
    assign serial_clock_pin_drive          = r.sclk;
    assign serial_clock_pin_en             = r.sclk_oe;
    assign slave_in_master_out_pin_drive   = r.out_bit;
    assign slave_in_master_out_pin_en      = r.mo_oe;
    assign slave_out_master_in_pin_drive   = r.out_bit;
    assign slave_out_master_in_pin_en      = r.so_oe;
    assign slave_transmit_enable_pin_drive = r.ste_drive;
    assign slave_transmit_enable_pin_en    = r.ste_oe;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_kick;
        r.tx_full ##1 r.st == ST_SHIFT;
    endsequence

    a_master_start: assert property ( // RQ18
        (bus_wr && bus_addr == ADDR_TXBUF && r.st == ST_IDLE && master
         && en && !r.tx_full) ##1 $stable(r.ctl) |-> s_kick)
        else $error("master did not start after buffer write");

    a_idle_clock: assert property ( // RQ18
        (r.st == ST_IDLE && $past(r.st) == ST_IDLE && $stable(r.cfg))
        |-> r.sclk == r.cfg[CFG_POL])
        else $error("serial clock not at idle level between words");

    a_done_capture: assert property ( // RQ17
        finish |=> r.rx_done && r.st == ST_IDLE
        && r.rxbuf == ($past(next_r.sh) & $past(lenmask)))
        else $error("received word not captured on completion");

    a_done_set_wins: assert property ( // RQ17
        (finish && bus_rd && bus_addr == ADDR_RXBUF) |=> r.rx_done)
        else $error("completion lost to a clearing read");

    a_overrun_set: assert property ( // RQ11
        (finish && r.rx_done) |=> r.overrun)
        else $error("unread word overwritten without overrun flag");

    a_rx_irq_tie: assert property ( // RQ11
        r.rx_irq == (r.rx_done && r.ctl[CTL_RX_IE]))
        else $error("receive interrupt does not follow flag and enable");

    a_pins_released: assert property ( // RQ14
        !r.ctl[CTL_PORT_EN] |-> !serial_clock_pin_en && !r.mo_oe
        && !r.so_oe && !slave_transmit_enable_pin_en)
        else $error("disabled port still drives a pin");

    a_talk_gate: assert property ( // RQ10
        !r.ctl[CTL_TALK] |-> !r.mo_oe && !r.so_oe)
        else $error("data pin driven with transmit turned off");

    a_upper_zero: assert property ( // RQ12
        (bus_rd && (bus_addr == ADDR_CONFIG || bus_addr == ADDR_OPCTL
         || bus_addr == ADDR_STATUS || bus_addr == ADDR_RATE))
        |=> r.rvalid && r.rdata[15:8] == 8'h00)
        else $error("control register upper byte not zero");

    a_slave_abort: assert property ( // RQ2
        (r.st == ST_SHIFT && !master && !ste_low) |=> r.st == ST_IDLE)
        else $error("slave kept shifting while deselected");

    a_slave_start: assert property ( // RQ2
        (r.st == ST_IDLE && en && !master && ste_low) |=> r.st == ST_SHIFT)
        else $error("selected slave did not start shifting");

    a_tx_irq_tie: assert property ( // RQ11
        r.tx_irq == (!r.tx_full && r.ctl[CTL_TX_IE]))
        else $error("transmit interrupt does not follow flag and enable");

    a_txbuf_load: assert property ( // RQ18
        (bus_wr && bus_addr == ADDR_TXBUF) |=> r.tx_full)
        else $error("buffer write did not mark the buffer full");

    sequence s_go;
        r.go ##1 r.st == ST_SHIFT;
    endsequence

    a_data_start: assert property ( // RQ18
        (bus_wr && bus_addr == ADDR_SHIFT && r.st == ST_IDLE && master
         && en && !r.tx_full && !r.go) ##1 $stable(r.ctl) |-> s_go)
        else $error("master did not start after data register write");

endmodule : spi_master_slave_port

// file: bench/spi_far_end_model.sv
// Behavioural peripheral on the far side of the serial port
`timescale 1ns/1ps
module spi_far_end_model (
    input  wire logic        sclk,
    input  wire logic        sel_n,
    input  wire logic        mosi,
    input  wire logic        pol,
    input  wire logic        phase,
    input  wire logic [15:0] word,
    output logic             miso,
    output logic [15:0]      got
);
    int   idx;
    logic sel_q;
    initial begin
        miso  = 1'b0;
        got   = 16'h0000;
        idx   = 15;
        sel_q = 1'b1;
    end
    // Selection seen one step late so the closing edge still counts
    always @(sel_n) begin
        sel_q <= sel_n;
    end
    // Delayed schemes present the first bit at selection
    always @(negedge sel_n) begin
        got = 16'h0000;
        idx = 15;
        if (phase) begin
            miso = word[15];
            idx  = 14;
        end
    end
    always @(sclk) begin
        if (!sel_q) begin
            if ((sclk != pol) == phase) begin
                got = {got[14:0], mosi};
            end else if (idx >= 0) begin
                miso = word[idx];
                idx  = idx - 1;
            end
        end
    end
    // Released line shows no stale value
    always @(posedge sel_n) begin
        miso = ~miso;
    end
endmodule : spi_far_end_model

// file: bench/test_spi_master_slave_port.sv
// Self-checking bench for the serial port with a far-end peripheral
`timescale 1ns/1ps
module test_spi_master_slave_port;
    import spi_port_pkg::*;
    logic        clk, nrst, wr, rd, rvalid, rx_irq, tx_irq;
    logic [15:0] addr, wdata, rdata, mword, got, rv;
    logic        sc_drv, sc_en, mo_drv, mo_en, mi_drv, mi_en, se_drv, se_en;
    logic        tb_sclk, tb_sel_n, tb_mosi, pol, phase, fmiso;
    int          n_errors, n_compared;
    wire logic   sc_lvl = sc_en ? sc_drv : tb_sclk;
    wire logic   mo_lvl = mo_en ? mo_drv : tb_mosi;
    wire logic   mi_lvl = mi_en ? mi_drv : fmiso;
    wire logic   se_lvl = se_en ? se_drv : tb_sel_n;

    spi_master_slave_port uut (
        .clk(clk), .nrst(nrst), .bus_addr(addr), .bus_wdata(wdata),
        .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata), .bus_rvalid(rvalid),
        .rx_int_req(rx_irq), .tx_int_req(tx_irq),
        .serial_clock_pin_level(sc_lvl), .serial_clock_pin_drive(sc_drv),
        .serial_clock_pin_en(sc_en),
        .slave_in_master_out_pin_level(mo_lvl),
        .slave_in_master_out_pin_drive(mo_drv),
        .slave_in_master_out_pin_en(mo_en),
        .slave_out_master_in_pin_level(mi_lvl),
        .slave_out_master_in_pin_drive(mi_drv),
        .slave_out_master_in_pin_en(mi_en),
        .slave_transmit_enable_pin_level(se_lvl),
        .slave_transmit_enable_pin_drive(se_drv),
        .slave_transmit_enable_pin_en(se_en)
    );
    spi_far_end_model far (
        .sclk(sc_lvl), .sel_n(se_lvl), .mosi(mo_lvl), .pol(pol),
        .phase(phase), .word(mword), .miso(fmiso), .got(got)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h, expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clk);
        addr = a;
        rd   = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        check(16'(rvalid), 16'h0001);
        check(rdata, exp);
    endtask : rd_chk

    task end_sim;
        $display("errors %0d, compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task t_regs;
        rd_chk(ADDR_CONFIG, 16'h0000);
        rd_chk(ADDR_STATUS, 16'h0000);
        rd_chk(16'h7043, 16'h0000);
        check(16'({sc_en, mo_en, mi_en, se_en}), 16'h0000);
        wr_reg(ADDR_CONFIG, 16'hFF4F);
        rd_chk(ADDR_CONFIG, 16'h004F);
        wr_reg(ADDR_RATE, 16'hFFFF);
        rd_chk(ADDR_RATE, 16'h007F);
        wr_reg(ADDR_FIFO_TX, 16'h1234);
        rd_chk(ADDR_FIFO_TX, 16'h0000);
        wr_reg(ADDR_OPCTL, 16'h0010);
        @(negedge clk);
        check(16'(tx_irq), 16'h0001);
        rd_chk(ADDR_OPCTL, 16'h0010);
    endtask : t_regs

    task xfer(input logic p, input logic ph, input int len, input int div,
              input logic [15:0] mw, input logic [15:0] sw,
              input logic talk);
        int per;
        int cnt;
        int i;
        per   = (div >= 4) ? div + 1 : 4;
        cnt   = 0;
        i     = 0;
        pol   = p;
        phase = ph;
        mword = sw;
        wr_reg(ADDR_CONFIG, 16'(len - 1) | (16'(p) << 6));
        wr_reg(ADDR_RATE, 16'(div));
        wr_reg(ADDR_OPCTL, {10'h000, 1'b1, 1'b0, ph, 1'b1, talk, 1'b1});
        @(negedge clk);
        check(16'(sc_drv), 16'(p));
        check(16'({sc_en, mo_en, se_en}), {13'h0, 1'b1, talk, 1'b1});
        // Silent run starts from the data register instead
        wr_reg(talk ? ADDR_TXBUF : ADDR_SHIFT, mw);
        while (rx_irq !== 1'b1 && i < 5000) begin
            @(negedge clk);
            if (sc_drv !== p) cnt++;
            i++;
        end
        check(16'(rx_irq), 16'h0001);
        check(16'(cnt), 16'(len * (per - per / 2)));
        check(16'(sc_drv), 16'(p));
        rd_chk(ADDR_STATUS, 16'h0040);
        rd_chk(ADDR_RXBUF, sw >> (16 - len));
        @(negedge clk);
        check(16'(rx_irq), 16'h0000);
        if (talk) check(got, mw >> (16 - len));
    endtask : xfer

    task t_slave(input logic [7:0] b);
        int i;
        wr_reg(ADDR_CONFIG, 16'h0007);
        wr_reg(ADDR_OPCTL, 16'h0023);
        wr_reg(ADDR_TXBUF, 16'h5A00);
        rv = 16'h0000;
        @(negedge clk);
        tb_sel_n = 1'b0;
        repeat (4) @(negedge clk);
        check(16'({mi_en, sc_en}), 16'h0002);
        for (i = 7; i >= 0; i--) begin
            tb_sclk = 1'b1;
            tb_mosi = b[i];
            repeat (4) @(negedge clk);
            rv = {rv[14:0], mi_drv};
            tb_sclk = 1'b0;
            repeat (4) @(negedge clk);
        end
        check(rv, 16'h005A);
        i = 0;
        while (rx_irq !== 1'b1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        check(16'(rx_irq), 16'h0001);
        tb_sel_n = 1'b1;
        tb_mosi  = ~tb_mosi;
        rd_chk(ADDR_RXBUF, {8'h00, b});
        wr_reg(ADDR_OPCTL, 16'h0000);
        @(negedge clk);
        check(16'({sc_en, mo_en, mi_en, se_en}), 16'h0000);
    endtask : t_slave

    task t_overrun;
        wr_reg(ADDR_TXBUF, 16'h8000);
        repeat (20) @(negedge clk);
        wr_reg(ADDR_TXBUF, 16'h8000);
        repeat (20) @(negedge clk);
        rd_chk(ADDR_STATUS, 16'h00C0);
        wr_reg(ADDR_STATUS, 16'h0080);
        rd_chk(ADDR_STATUS, 16'h0040);
        rd_chk(ADDR_RXBUF, 16'h0001);
    endtask : t_overrun

    initial begin
        #100000;
        n_errors++;
        end_sim();
    end

    initial begin
        n_errors   = 0;
        n_compared = 0;
        nrst       = 1'b0;
        addr       = 16'h0000;
        wdata      = 16'h0000;
        wr         = 1'b0;
        rd         = 1'b0;
        tb_sclk    = 1'b0;
        tb_sel_n   = 1'b1;
        tb_mosi    = 1'b0;
        pol        = 1'b0;
        phase      = 1'b0;
        mword      = 16'h0000;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        t_regs();
        xfer(1'b0, 1'b0, 8, 2, 16'hA5C3, 16'h3C5A, 1'b1);
        xfer(1'b0, 1'b1, 8, 9, 16'h5AF0, 16'hC396, 1'b1);
        xfer(1'b1, 1'b0, 16, 8, 16'hB14E, 16'h7E81, 1'b1);
        xfer(1'b1, 1'b1, 1, 3, 16'h8000, 16'hFFFF, 1'b1);
        t_overrun();
        xfer(1'b0, 1'b0, 5, 127, 16'h0000, 16'hD800, 1'b0);
        t_slave(8'h96);
        end_sim();
    end
endmodule : test_spi_master_slave_port
